// ### dcr_pkg.sv
// Constants and types shared by the debug control register logic
package dcr_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int unsigned APB_ADDR_W = 12;
  localparam logic [11:0] DEBUG_CONTROL_OFFSET = 12'h000;
  localparam logic [7:0] DEBUG_CONTROL_RESET = 8'h00;
  localparam logic [31:0] APB_READ_ZERO = 32'h0000_0000;

  // ************************************************************
  // Field positions of debug_control
  // ************************************************************
  localparam int unsigned HALT_BIT = 7;
  localparam int unsigned ARM_BIT = 6;
  localparam int unsigned ACK_BIT = 5;
  localparam int unsigned RSV_HI_BIT = 4;
  localparam int unsigned RSV_LO_BIT = 1;
  localparam int unsigned SELF_RESET_BIT = 0;

  // ************************************************************
  // Opcodes and debug command
  // ************************************************************
  localparam logic [7:0] BREAK_OPCODE = 8'h00;
  localparam logic [7:0] CMD_WRITE_OPCODE = 8'h12;
  localparam int unsigned MAX_OPCODE_BYTES = 5;
  localparam logic [2:0] COUNT_ZERO = 3'h0;
  localparam logic [2:0] COUNT_ONE = 3'h1;
  localparam logic [2:0] COUNT_MAX = 3'h5;

  // Debug command channel states
  typedef enum logic [1:0] {CMD_IDLE, CMD_COLLECT, CMD_DISCARD} dcr_cmd_state_t;

endpackage : dcr_pkg

// ### dcr_cmd_if.sv
// Carrier between the control register logic and the command channel
`timescale 1ns/1ns
interface dcr_cmd_if;
  import dcr_pkg::*;

  // Mode seen by the command channel
  logic in_debug;
  logic rd_protect;
  // Opcode injection toward the core
  logic inject_valid;
  logic [MAX_OPCODE_BYTES-1:0][7:0] inject_bytes;
  logic [2:0] inject_count;
  logic discard;

  modport ctl (output in_debug, output rd_protect, input inject_valid, input inject_bytes,
               input inject_count, input discard);
  modport cmd (input in_debug, input rd_protect, output inject_valid, output inject_bytes,
               output inject_count, output discard);
endinterface : dcr_cmd_if

// ### dcr_cmd.sv
// Debug pin command channel for the opcode write command
`timescale 1ns/1ns
module dcr_cmd (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Byte stream from the debug pin
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic byte_last,
  // Link to the control register logic
  dcr_cmd_if.cmd link
);
  import dcr_pkg::*;

  dcr_cmd_state_t state, next_state;
  logic [MAX_OPCODE_BYTES-1:0][7:0] bytes, next_bytes;
  logic [2:0] count, next_count;
  logic inject_valid, next_inject_valid;
  logic discard, next_discard;

  // ************************************************************
  // Command sequencing
  // ************************************************************
  // Next state of the command channel
  always_comb begin
    next_state = state;
    next_bytes = bytes;
    next_count = count;
    next_inject_valid = 1'b0;
    next_discard = 1'b0;
    case (state)
      CMD_IDLE: begin
        if (byte_valid && (byte_data == CMD_WRITE_OPCODE)) begin
          next_count = COUNT_ZERO;
          if (!link.in_debug || link.rd_protect) begin
            next_state = CMD_DISCARD;
          end else begin
            next_state = CMD_COLLECT;
          end
        end
      end
      CMD_COLLECT: begin
        if (byte_valid) begin
          next_bytes[count] = byte_data;
          next_count = count + COUNT_ONE;
          if (byte_last || (next_count == COUNT_MAX)) begin
            next_inject_valid = 1'b1;
            next_state = CMD_IDLE;
          end
        end
      end
      CMD_DISCARD: begin
        if (byte_valid) begin
          next_discard = 1'b1;
          next_state = CMD_IDLE;
        end
      end
      default: begin
        next_state = CMD_IDLE;
      end
    endcase
  end

  // Register the channel state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= CMD_IDLE;
      bytes <= '0;
      count <= COUNT_ZERO;
      inject_valid <= 1'b0;
      discard <= 1'b0;
    end else begin
      state <= next_state;
      bytes <= next_bytes;
      count <= next_count;
      inject_valid <= next_inject_valid;
      discard <= next_discard;
    end
  end

  // Outputs straight from flops
  assign link.inject_valid = inject_valid;
  assign link.inject_bytes = bytes;
  assign link.inject_count = count;
  assign link.discard = discard;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_discard_one_byte: assert property ((state == CMD_DISCARD) && byte_valid |=> discard && (state == CMD_IDLE))
    else $error("discard did not take exactly one byte");
  a_inject_count_range: assert property (inject_valid |-> (count >= COUNT_ONE) && (count <= COUNT_MAX))
    else $error("opcode count outside one to five");
  a_blocked_no_inject: assert property ((state == CMD_IDLE) && byte_valid && (byte_data == CMD_WRITE_OPCODE)
    && !link.in_debug |=> (state == CMD_DISCARD) ##1 !inject_valid)
    else $error("command outside debug mode was not discarded");

  c_inject_five: cover property (inject_valid && (count == COUNT_MAX));
  c_discard: cover property (discard);
endmodule : dcr_cmd

// ### dcr_top.sv
// Debug control register logic with APB access and command channel
// Summary of operation
// - Halt flag set stops core instruction fetch
// - Clearing halt flag resumes core fetching
// - Armed break opcode decode sets halt flag
// - Unarmed break opcode acts as no-operation
// - Read protect ignores writes clearing halt
// - Self reset bit requests device reset
// - Host resumes by writing halt flag clear
// - Opcode command; blocked mode discards one byte
// - Resets to zero; bits 4..1 read-only
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module dcr_top (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [dcr_pkg::APB_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Core decode and fetch
  input wire logic DECODE_VALID,
  input wire logic [7:0] DECODE_OPCODE,
  input wire logic CORE_FETCH_IDLE,
  output logic FETCH_HALT,
  output logic DEBUG_ACK,
  // Device options and reset
  input wire logic FLASH_RD_PROTECT,
  output logic SYS_RESET_REQ,
  // Debug pin byte stream
  input wire logic DBG_BYTE_VALID,
  input wire logic [7:0] DBG_BYTE,
  input wire logic DBG_BYTE_LAST,
  // Opcode injection toward the core
  output logic OPCODE_INJECT_VALID,
  output logic [dcr_pkg::MAX_OPCODE_BYTES*8-1:0] OPCODE_INJECT_BYTES,
  output logic [2:0] OPCODE_INJECT_COUNT,
  output logic OPCODE_DISCARD
);
  import dcr_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic halt, next_halt;
  logic arm, next_arm;
  logic ack, next_ack;
  logic self_reset, next_self_reset;
  logic pready, next_pready;
  logic pslverr, next_pslverr;
  logic [31:0] prdata, next_prdata;
  logic access;
  logic addr_hit;
  logic reg_write;
  logic break_hit;
  logic [7:0] read_val;

  dcr_cmd_if cmd_link ();

  // ************************************************************
  // APB decode
  // ************************************************************
  // Access phase, address match and committed write
  assign access = PSEL && PENABLE;
  assign addr_hit = (PADDR == DEBUG_CONTROL_OFFSET);
  assign reg_write = access && pready && PWRITE && addr_hit;

  // Read view: ack from core state, reserved bits zero
  always_comb begin
    read_val = DEBUG_CONTROL_RESET;
    read_val[HALT_BIT] = halt;
    read_val[ARM_BIT] = arm;
    read_val[ACK_BIT] = ack;
    read_val[SELF_RESET_BIT] = self_reset;
  end

  // Bus answer one cycle into the access phase
  always_comb begin
    next_pready = access && !pready;
    next_pslverr = access && !pready && !addr_hit;
    next_prdata = prdata;
    if (access && !pready) begin
      next_prdata = APB_READ_ZERO;
      if (addr_hit && !PWRITE) begin
        next_prdata[7:0] = read_val;
      end
    end
  end

  // Register the bus answer
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= APB_READ_ZERO;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ************************************************************
  // Debug control state
  // ************************************************************
  // Armed break opcode from the decoder
  assign break_hit = DECODE_VALID && (DECODE_OPCODE == BREAK_OPCODE) && arm;

  // Next values of the control bits
  always_comb begin
    next_halt = halt;
    next_arm = arm;
    next_self_reset = 1'b0;
    if (reg_write) begin
      next_arm = PWDATA[ARM_BIT];
      next_self_reset = PWDATA[SELF_RESET_BIT];
      if (PWDATA[HALT_BIT] || !FLASH_RD_PROTECT) begin
        next_halt = PWDATA[HALT_BIT];
      end
    end
    if (break_hit) begin
      next_halt = 1'b1;
    end
    next_ack = halt && CORE_FETCH_IDLE;
  end

  // Register the control bits
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      halt <= DEBUG_CONTROL_RESET[HALT_BIT];
      arm <= DEBUG_CONTROL_RESET[ARM_BIT];
      ack <= DEBUG_CONTROL_RESET[ACK_BIT];
      self_reset <= DEBUG_CONTROL_RESET[SELF_RESET_BIT];
    end else begin
      halt <= next_halt;
      arm <= next_arm;
      ack <= next_ack;
      self_reset <= next_self_reset;
    end
  end

  // ************************************************************
  // Command channel
  // ************************************************************
  // Mode handed to the channel
  assign cmd_link.in_debug = halt;
  assign cmd_link.rd_protect = FLASH_RD_PROTECT;

  dcr_cmd u_cmd (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .byte_valid(DBG_BYTE_VALID),
    .byte_data(DBG_BYTE),
    .byte_last(DBG_BYTE_LAST),
    .link(cmd_link.cmd)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  // All outputs come straight from flops
  assign PRDATA = prdata;
  assign PREADY = pready;
  assign PSLVERR = pslverr;
  assign FETCH_HALT = halt;
  assign DEBUG_ACK = ack;
  assign SYS_RESET_REQ = self_reset;
  assign OPCODE_INJECT_VALID = cmd_link.inject_valid;
  assign OPCODE_INJECT_BYTES = cmd_link.inject_bytes;
  assign OPCODE_INJECT_COUNT = cmd_link.inject_count;
  assign OPCODE_DISCARD = cmd_link.discard;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  a_halt_write_stops: assert property (reg_write && PWDATA[HALT_BIT] |=> FETCH_HALT)
    else $error("halt write did not stop fetch");
  a_clear_resumes: assert property (reg_write && !PWDATA[HALT_BIT] && !FLASH_RD_PROTECT && !break_hit
    |=> !FETCH_HALT ##1 !DEBUG_ACK)
    else $error("clearing halt did not resume fetch");
  a_break_sets_halt: assert property (break_hit |=> FETCH_HALT)
    else $error("armed break did not halt");
  a_unarmed_break_nop: assert property (DECODE_VALID && (DECODE_OPCODE == BREAK_OPCODE) && !arm
    && !halt && !reg_write |=> !halt)
    else $error("unarmed break changed mode");
  a_protect_holds_halt: assert property (halt && FLASH_RD_PROTECT |=> halt)
    else $error("protected halt was cleared");
  a_self_reset_pulse: assert property (reg_write && PWDATA[SELF_RESET_BIT] |=> SYS_RESET_REQ ##1 !SYS_RESET_REQ)
    else $error("self reset not one pulse");
  a_resume_in_debug: assert property (halt && reg_write && !PWDATA[HALT_BIT] && !FLASH_RD_PROTECT && !break_hit
    |=> !halt && (PRDATA == $past(PRDATA)))
    else $error("run write in debug mode failed");
  a_reserved_read_zero: assert property (PREADY && !PSLVERR |-> PRDATA[RSV_HI_BIT:RSV_LO_BIT] == '0)
    else $error("reserved bits read nonzero");
  a_ack_when_stopped: assert property (halt && CORE_FETCH_IDLE |=> DEBUG_ACK)
    else $error("ack missing after fetch stopped");
  a_ack_low_running: assert property (!halt |=> !DEBUG_ACK)
    else $error("ack high while running");
  a_apb_one_wait: assert property (access && !pready |=> PREADY ##1 !PREADY)
    else $error("bus answer timing wrong");
  // Writes land only on the mapped register; discard pulse is one cycle
  a_arm_follows_write: assert property (reg_write |=> arm == $past(PWDATA[ARM_BIT]))
    else $error("breakpoint arm bit did not take the write");
  a_unmapped_no_write: assert property (access && pready && PWRITE && !addr_hit |=> $stable(arm))
    else $error("unmapped write changed the register");
  a_discard_one_cycle: assert property (OPCODE_DISCARD |=> !OPCODE_DISCARD)
    else $error("discard pulse longer than one cycle");

  c_break_halt: cover property (break_hit);
  c_self_reset: cover property (SYS_RESET_REQ && FETCH_HALT);
  c_protect_block: cover property (reg_write && !PWDATA[HALT_BIT] && FLASH_RD_PROTECT && halt);
  c_unmapped: cover property (PREADY && PSLVERR);
endmodule : dcr_top

// ### dcr_top_note_end.sv
// Spare file of the debug control register logic; holds no logic

// ### dcr_dbg_host.sv
// Debug host model driving the opcode byte stream
`timescale 1ns/1ns
module dcr_dbg_host
  import dcr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Byte stream toward the device
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic byte_last
);
  // Idle stream at time zero
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    byte_last = 1'b0;
  end

  // One byte, then the data line shows the inverse so stale data never looks valid
  task automatic send(input logic [7:0] b, input logic lst, input int gap);
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_data <= b;
    byte_last <= lst;
    @(posedge clk);
    byte_valid <= 1'b0;
    byte_data <= ~b;
    byte_last <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask : send

  // Command byte followed by n opcode bytes, last one flagged
  task automatic command(input int n, input logic [39:0] ops, input int gap);
    send(CMD_WRITE_OPCODE, 1'b0, gap);
    for (int k = 0; k < n; k++) begin
      send(ops[8*k +: 8], k == n - 1, gap);
    end
  endtask : command
endmodule : dcr_dbg_host

// ### tb.sv
// Self-checking testbench for the debug control register logic
`timescale 1ns/1ns
module tb;
  import dcr_pkg::*;
  // ************************************************************
  // Signals and bookkeeping
  // ************************************************************
  logic CORE_CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA;
  logic DECODE_VALID = 1'b0, CORE_FETCH_IDLE = 1'b0, FLASH_RD_PROTECT = 1'b0;
  logic [7:0] DECODE_OPCODE = 8'h00, DBG_BYTE;
  logic PREADY, PSLVERR, FETCH_HALT, DEBUG_ACK, SYS_RESET_REQ, DBG_BYTE_VALID, DBG_BYTE_LAST;
  logic OPCODE_INJECT_VALID, OPCODE_DISCARD;
  logic [39:0] OPCODE_INJECT_BYTES, ops;
  logic [2:0] OPCODE_INJECT_COUNT;
  logic [33:0] apb_q[$], e;
  logic [42:0] inj_q[$], f;
  logic disc_q[$], rst_q[$];
  int error_cnt = 0, cmp_count = 0;

  // Free-running core clock
  always #4 CORE_CLK = ~CORE_CLK;

  dcr_top uut (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DECODE_VALID(DECODE_VALID), .DECODE_OPCODE(DECODE_OPCODE), .CORE_FETCH_IDLE(CORE_FETCH_IDLE),
    .FETCH_HALT(FETCH_HALT), .DEBUG_ACK(DEBUG_ACK), .FLASH_RD_PROTECT(FLASH_RD_PROTECT),
    .SYS_RESET_REQ(SYS_RESET_REQ), .DBG_BYTE_VALID(DBG_BYTE_VALID), .DBG_BYTE(DBG_BYTE),
    .DBG_BYTE_LAST(DBG_BYTE_LAST), .OPCODE_INJECT_VALID(OPCODE_INJECT_VALID),
    .OPCODE_INJECT_BYTES(OPCODE_INJECT_BYTES), .OPCODE_INJECT_COUNT(OPCODE_INJECT_COUNT),
    .OPCODE_DISCARD(OPCODE_DISCARD));

  dcr_dbg_host host (.clk(CORE_CLK), .byte_valid(DBG_BYTE_VALID), .byte_data(DBG_BYTE),
    .byte_last(DBG_BYTE_LAST));

  // ************************************************************
  // Compare, bus and closing tasks
  // ************************************************************
  task automatic cmp_bus(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t apb got %h exp %h", $time, got, exp);
    end
  endtask : cmp_bus

  task automatic cmp_inj(input logic [42:0] got, input logic [42:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t inject got %h exp %h", $time, got, exp);
    end
  endtask : cmp_inj

  task automatic cmp_lvl(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t level got %b exp %b", $time, got, exp);
    end
  endtask : cmp_lvl

  // One transfer; read data expectation goes to the queue
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [7:0] x);
    apb_q.push_back({~wr, a != DEBUG_CONTROL_OFFSET, 24'h00_0000, x});
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1) begin
      @(posedge CORE_CLK);
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic break_opcode(input logic [7:0] op);
    @(posedge CORE_CLK);
    DECODE_VALID <= 1'b1;
    DECODE_OPCODE <= op;
    @(posedge CORE_CLK);
    DECODE_VALID <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
  endtask : break_opcode

  task automatic end_of_test();
    if (apb_q.size() + inj_q.size() + disc_q.size() + rst_q.size() != 0) begin
      error_cnt++;
      $display("ERROR %0t expected results never appeared", $time);
    end
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Result monitor: each result takes the oldest note of its kind
  always @(posedge CORE_CLK) begin
    if (PREADY === 1'b1) begin
      e = apb_q.size() ? apb_q.pop_front() : 'x;
      cmp_bus({PSLVERR, e[33] ? PRDATA : 32'h0000_0000}, e[32:0]);
    end
    if (OPCODE_INJECT_VALID === 1'b1) begin
      f = inj_q.size() ? inj_q.pop_front() : 'x;
      cmp_inj({OPCODE_INJECT_COUNT, OPCODE_INJECT_BYTES & ~({40{1'b1}} << (8 * f[42:40]))}, f);
    end
    if (OPCODE_DISCARD === 1'b1) begin
      cmp_lvl(disc_q.size() != 0, 1'b1);
      if (disc_q.size()) void'(disc_q.pop_front());
    end
    if (SYS_RESET_REQ === 1'b1) begin
      cmp_lvl(rst_q.size() != 0, 1'b1);
      if (rst_q.size()) void'(rst_q.pop_front());
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'hb32b));
    repeat (6) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    apb(1'b0, DEBUG_CONTROL_OFFSET, 32'h0000_0000, 8'h00);
    rst_q.push_back(1'b1);
    apb(1'b1, DEBUG_CONTROL_OFFSET, 32'h0000_00ff, 8'h00);
    repeat (2) @(posedge CORE_CLK);
    cmp_lvl(FETCH_HALT, 1'b1);
    apb(1'b0, DEBUG_CONTROL_OFFSET, 32'h0000_0000, 8'hc0);
    CORE_FETCH_IDLE <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    cmp_lvl(DEBUG_ACK, 1'b1);
    apb(1'b0, DEBUG_CONTROL_OFFSET, 32'h0000_0000, 8'he0);
    // Every opcode count while halted, prompt and slow host
    for (int n = 1; n <= 5; n++) begin
      ops = 40'({$urandom, $urandom});
      inj_q.push_back({3'(n), ops & ~({40{1'b1}} << (8 * n))});
      host.command(n, ops, n % 2);
    end
    apb(1'b1, DEBUG_CONTROL_OFFSET, 32'h0000_0040, 8'h00);
    repeat (2) @(posedge CORE_CLK);
    cmp_lvl(FETCH_HALT, 1'b0);
    cmp_lvl(DEBUG_ACK, 1'b0);
    CORE_FETCH_IDLE <= 1'b0;
    disc_q.push_back(1'b1);
    host.command(1, 40'({$urandom, $urandom}), 0);
    // Break only with the exact opcode and arm set
    break_opcode(8'h5a);
    cmp_lvl(FETCH_HALT, 1'b0);
    break_opcode(BREAK_OPCODE);
    cmp_lvl(FETCH_HALT, 1'b1);
    apb(1'b1, DEBUG_CONTROL_OFFSET, 32'h0000_0000, 8'h00);
    break_opcode(BREAK_OPCODE);
    cmp_lvl(FETCH_HALT, 1'b0);
    // Read protect locks halt until reset
    FLASH_RD_PROTECT <= 1'b1;
    apb(1'b1, DEBUG_CONTROL_OFFSET, 32'h0000_0080, 8'h00);
    apb(1'b1, DEBUG_CONTROL_OFFSET, 32'h0000_0000, 8'h00);
    apb(1'b0, DEBUG_CONTROL_OFFSET, 32'h0000_0000, 8'h80);
    disc_q.push_back(1'b1);
    host.command(1, 40'({$urandom, $urandom}), 1);
    RST_B <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    FLASH_RD_PROTECT <= 1'b0;
    apb(1'b0, DEBUG_CONTROL_OFFSET, 32'h0000_0000, 8'h00);
    // Unmapped addresses answer with an error and change nothing
    apb(1'b1, 12'h008, $urandom, 8'h00);
    apb(1'b0, 12'h004, 32'h0000_0000, 8'h00);
    apb(1'b0, DEBUG_CONTROL_OFFSET, 32'h0000_0000, 8'h00);
    repeat (5) @(posedge CORE_CLK);
    end_of_test();
  end
endmodule : tb
